// *** irs_defines.vh ***
// constants of the initial reset sequencer: timing, register map, reset values
// assumes a single 200 MHz system clock and a 32.768 kHz low-speed rate made by division
//
// Overview of operation
// [R1] Reset pin, key-group low or supply monitor each hold CPU and peripherals in reset.
// [R2] After release, the reset vector is read at addresses 0 and 1, then execution starts.
// [R3] Key group is a build option: none, keys 0-1, keys 0-2 or keys 0-3.
// [R4] Outside bypass, the chosen keys must stay low two seconds before reset asserts.
// [R5] In sleep or stabilization wait, key-group low resets at once, without qualification.
// [R6] With monitor option, four low samples assert reset until supply reaches level 2.
// [R7] At power-on with monitor option, reset holds until a sample reads level 2 or more.
// [R8] After reset release, CPU start waits 8192 low-speed cycles for oscillator stabilization.
// [R9] With monitor option, a further 248 low-speed cycles of sampling wait are added.
// [R10] Key reset in sleep: CPU starts after keys release, then the normal waits.
// [R11] Key reset outside sleep is a 64-cycle pulse; CPU restarts even with keys low.
// [R12] Reset clears the six arithmetic flags and sets both interrupt mask flags.
// [R13] Reset loads new code bank with 01 and the three expand pages with 00.
// [R14] Vector fetch loads the program counter and copies new code bank into current bank.
// [R15] Internal RAM and display memory are not touched by reset.
// [R16] Board circuit must give the first power-on reset through the reset pin.
// [R17] System must not pull all chosen keys low together in normal operation.
// [R18] Monitor busy status reads 1 after reset until the first sample completes; the code sets busy only after srst, not after pin, key or monitor resets.
// [R19] Sources are ORed and the request is synchronized to the low-speed rate.
`ifndef IRS_DEFINES_VH
`define IRS_DEFINES_VH

// rates and times
`define IRS_CLK_HZ 200000000
`define IRS_LS_HZ 32768
`define IRS_LS_DIV ((`IRS_CLK_HZ + `IRS_LS_HZ - 1) / `IRS_LS_HZ)
`define IRS_KEY_QUAL_S 2
`define IRS_KEY_QUAL_TICKS (`IRS_KEY_QUAL_S * `IRS_LS_HZ)
`define IRS_OSC_WAIT_TICKS 8192
`define IRS_SVD_WAIT_TICKS 248
`define IRS_KEY_PULSE_TICKS 7'h40
`define IRS_SVD_LOW_RUN 3'h4

// register map (byte addresses)
`define IRS_ADDR_STATUS 4'h0
`define IRS_ADDR_CAUSE 4'h4
`define IRS_ADDR_PC_LO 4'h8
`define IRS_ADDR_PC_HI 4'hc

// status fields
`define IRS_ST_BUSY 0
`define IRS_ST_CPU_RESET 1
`define IRS_ST_SVD_TRIP 2
`define IRS_ST_KEY_LOW 3

// cause fields
`define IRS_CA_PIN 0
`define IRS_CA_KEY 1
`define IRS_CA_SVD 2

// cpu reset values
`define IRS_FLAGS_RESET 8'hc0
`define IRS_NB_RESET 8'h01
`define IRS_EP_RESET 8'h00
`define IRS_VEC_ADDR_LO 24'h000000
`define IRS_VEC_ADDR_HI 24'h000001

`endif

// *** initial_reset_sequencer.v ***
// initial reset sequencer: merges reset sources, runs the start-up waits and the vector fetch
// assumes pins arrive asynchronously; sleep, monitor samples and vector data are on clk
//
// The plain strobed port and the register addresses were left to the implementer.
`timescale 1ns/100ps
`include "irs_defines.vh"

module initial_reset_sequencer #(
   parameter LS_DIV = `IRS_LS_DIV,
   parameter QUAL_TICKS = `IRS_KEY_QUAL_TICKS,
   parameter OSC_TICKS = `IRS_OSC_WAIT_TICKS,
   parameter [1:0] KEY_GROUP = 2'h3,
   parameter SVD_OPT = 1
) (
   input wire clk,
   input wire srst,
   input wire reset_pin_n,
   input wire key_pin_0,
   input wire key_pin_1,
   input wire key_pin_2,
   input wire key_pin_3,
   input wire sleep_active,
   input wire svd_sample_stb,
   input wire svd_below_l0,
   input wire svd_at_l2,
   input wire [7:0] vec_data,
   output reg vec_rd_r,
   output reg [23:0] vec_addr_r,
   output reg cpu_reset_r,
   output reg cpu_start_r,
   output reg [15:0] pc_init_r,
   output reg [7:0] cpu_flags_r,
   output reg [7:0] new_code_bank_r,
   output reg [7:0] current_code_bank_r,
   output reg [7:0] expand_page_r,
   output reg [7:0] expand_page_x_r,
   output reg [7:0] expand_page_y_r,
   output wire svd_busy,
   input wire [3:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [7:0] reg_rdata_r
);

   // ****************************************************************
   // declarations
   // ****************************************************************
   localparam CW = 17;
   localparam [2:0] ST_HOLD = 3'h0;
   localparam [2:0] ST_OSC = 3'h1;
   localparam [2:0] ST_SVD = 3'h2;
   localparam [2:0] ST_VLO = 3'h3;
   localparam [2:0] ST_VHI = 3'h4;
   localparam [2:0] ST_LOAD = 3'h5;
   localparam [2:0] ST_RUN = 3'h6;

   reg [2:0] state_r;
   reg [2:0] state_nxt;
   reg [CW-1:0] wait_r;
   reg [CW-1:0] wait_nxt;
   reg [12:0] div_r;
   reg ls_tick_r;
   reg pin_s1_r;
   reg pin_s2_r;
   reg [3:0] key_s1_r;
   reg [3:0] key_s2_r;
   reg [CW-1:0] qual_r;
   reg [6:0] pulse_r;
   reg fired_r;
   reg key_hold_r;
   reg [2:0] low_run_r;
   reg svd_trip_r;
   reg svd_good_r;
   reg first_done_r;
   reg req_ls_r;
   reg [2:0] cause_r;
   reg [7:0] vec_lo_r;
   wire [3:0] key_raw;
   wire [3:0] key_mask;
   wire key_low;
   wire bypass;
   wire key_pulse;
   wire req_comb;

   assign key_raw = {key_pin_3, key_pin_2, key_pin_1, key_pin_0};

   // [R3] key group select
   assign key_mask = (KEY_GROUP == 2'h1) ? 4'h3 :
                     (KEY_GROUP == 2'h2) ? 4'h7 :
                     (KEY_GROUP == 2'h3) ? 4'hf : 4'h0;

   // ****************************************************************
   // pin synchronisers
   // ****************************************************************
   // two flops per key pin; the first flop feeds only the second
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : g_key
         always @(posedge clk) begin
            if (srst) begin
               key_s1_r[gi] <= 1'b1;
               key_s2_r[gi] <= 1'b1;
            end else begin
               key_s1_r[gi] <= key_raw[gi];
               key_s2_r[gi] <= key_s1_r[gi];
            end
         end
      end
   endgenerate

   // reset pin synchroniser, held low through srst so power-on counts as a pin reset
   always @(posedge clk) begin
      if (srst) begin
         pin_s1_r <= 1'b0;
         pin_s2_r <= 1'b0;
      end else begin
         pin_s1_r <= reset_pin_n;
         pin_s2_r <= pin_s1_r;
      end
   end

   // [R3] all chosen keys low at once
   assign key_low = (key_mask != 4'h0) && ((key_s2_r & key_mask) == 4'h0);

   // ****************************************************************
   // low-speed rate divider
   // ****************************************************************
   // one-cycle tick per low-speed period; rounding makes it a hair slow, never fast
   always @(posedge clk) begin
      if (srst) begin
         div_r <= 13'h0000;
         ls_tick_r <= 1'b0;
      end else begin
         ls_tick_r <= (div_r == 13'h0000);
         if (div_r == LS_DIV[12:0] - 13'h0001) begin
            div_r <= 13'h0000;
         end else begin
            div_r <= div_r + 13'h0001;
         end
      end
   end

   // ****************************************************************
   // key-group reset
   // ****************************************************************
   // [R5] bypass in sleep and in the stabilization wait
   assign bypass = sleep_active || (state_r == ST_OSC);
   assign key_pulse = (pulse_r != 7'h00);

   // [R5] immediate key reset; [R10] held until the keys are released
   // a press that already fired its pulse must not re-trip in the wait, so the cpu can start
   always @(posedge clk) begin
      if (srst) begin
         key_hold_r <= 1'b0;
      end else if (!key_low) begin
         key_hold_r <= 1'b0;
      end else if (bypass && !fired_r) begin
         key_hold_r <= 1'b1;
      end
   end

   // [R4] two-second qualifier; [R11] 64-tick pulse, fired once per press
   always @(posedge clk) begin
      if (srst) begin
         qual_r <= {CW{1'b0}};
         pulse_r <= 7'h00;
         fired_r <= 1'b0;
      end else begin
         if (!key_low || bypass || key_hold_r) begin
            qual_r <= {CW{1'b0}};
         end else if (ls_tick_r && !fired_r) begin
            qual_r <= qual_r + {{(CW-1){1'b0}}, 1'b1};
         end
         if (!key_low) begin
            fired_r <= 1'b0;
         end else if (ls_tick_r && !fired_r && !bypass && !key_hold_r &&
                      qual_r == QUAL_TICKS[CW-1:0] - {{(CW-1){1'b0}}, 1'b1}) begin
            fired_r <= 1'b1;
            pulse_r <= `IRS_KEY_PULSE_TICKS;
         end
         if (ls_tick_r && key_pulse) begin
            pulse_r <= pulse_r - 7'h01;
         end
      end
   end

   // ****************************************************************
   // supply monitor reset
   // ****************************************************************
   // [R6] four successive low samples trip, release at level 2
   always @(posedge clk) begin
      if (srst) begin
         low_run_r <= 3'h0;
         svd_trip_r <= 1'b0;
         svd_good_r <= 1'b0;
         first_done_r <= 1'b0;
      end else if (SVD_OPT != 0 && svd_sample_stb) begin
         // [R18] busy clears on the first completed sample
         first_done_r <= 1'b1;
         svd_good_r <= svd_at_l2;
         if (svd_below_l0) begin
            if (low_run_r != `IRS_SVD_LOW_RUN) begin
               low_run_r <= low_run_r + 3'h1;
            end
            if (low_run_r == `IRS_SVD_LOW_RUN - 3'h1) begin
               svd_trip_r <= 1'b1;
            end
         end else begin
            low_run_r <= 3'h0;
         end
         if (svd_at_l2) begin
            svd_trip_r <= 1'b0;
         end
      end
   end

   // [R18] busy status
   assign svd_busy = (SVD_OPT != 0) && !first_done_r;

   // ****************************************************************
   // request merge
   // ****************************************************************
   // [R1] [R19] sources ORed, then retimed to the low-speed tick
   assign req_comb = !pin_s2_r || key_hold_r || key_pulse || svd_trip_r;

   always @(posedge clk) begin
      if (srst) begin
         req_ls_r <= 1'b1;
      end else if (ls_tick_r) begin
         req_ls_r <= req_comb;
      end
   end

   // ****************************************************************
   // start-up sequence
   // ****************************************************************
   // waits advance on ticks, the vector fetch at full clock rate
   always @* begin
      state_nxt = state_r;
      wait_nxt = wait_r;
      case (state_r)
         ST_HOLD: begin
            // [R2] source removed, start the waits
            if (ls_tick_r && !req_ls_r) begin
               state_nxt = ST_OSC;
               wait_nxt = {CW{1'b0}};
            end
         end
         ST_OSC: begin
            // [R8] stabilization wait
            if (ls_tick_r) begin
               wait_nxt = wait_r + {{(CW-1){1'b0}}, 1'b1};
               if (wait_r == OSC_TICKS[CW-1:0] - {{(CW-1){1'b0}}, 1'b1}) begin
                  wait_nxt = {CW{1'b0}};
                  state_nxt = (SVD_OPT != 0) ? ST_SVD : ST_VLO;
               end
            end
         end
         ST_SVD: begin
            // [R9] sampling wait; [R7] stay until a sample shows level 2
            if (ls_tick_r) begin
               if (wait_r != `IRS_SVD_WAIT_TICKS) begin
                  wait_nxt = wait_r + {{(CW-1){1'b0}}, 1'b1};
               end else if (first_done_r && svd_good_r) begin
                  state_nxt = ST_VLO;
               end
            end
         end
         ST_VLO: state_nxt = ST_VHI;
         ST_VHI: state_nxt = ST_LOAD;
         ST_LOAD: state_nxt = ST_RUN;
         ST_RUN: state_nxt = ST_RUN;
         default: state_nxt = ST_HOLD;
      endcase
      // [R1] any synced request sends the sequence back to hold
      if (ls_tick_r && req_ls_r) begin
         state_nxt = ST_HOLD;
         wait_nxt = {CW{1'b0}};
      end
   end

   always @(posedge clk) begin
      if (srst) begin
         state_r <= ST_HOLD;
         wait_r <= {CW{1'b0}};
      end else begin
         state_r <= state_nxt;
         wait_r <= wait_nxt;
      end
   end

   // ****************************************************************
   // cpu register presets and vector fetch
   // ****************************************************************
   // [R15] only control registers here; ram and display memory are never written
   always @(posedge clk) begin
      if (srst) begin
         cpu_reset_r <= 1'b1;
         cpu_start_r <= 1'b0;
         vec_rd_r <= 1'b0;
         vec_addr_r <= `IRS_VEC_ADDR_LO;
         vec_lo_r <= 8'h00;
         pc_init_r <= 16'h0000;
         cpu_flags_r <= `IRS_FLAGS_RESET;
         new_code_bank_r <= `IRS_NB_RESET;
         current_code_bank_r <= 8'h00;
         expand_page_r <= `IRS_EP_RESET;
         expand_page_x_r <= `IRS_EP_RESET;
         expand_page_y_r <= `IRS_EP_RESET;
      end else begin
         cpu_reset_r <= (state_nxt != ST_RUN);
         cpu_start_r <= (state_r == ST_LOAD) && (state_nxt == ST_RUN);
         vec_rd_r <= (state_nxt == ST_VLO) || (state_nxt == ST_VHI);
         // [R2] low byte at address 0, high byte at address 1
         vec_addr_r <= (state_nxt == ST_VHI) ? `IRS_VEC_ADDR_HI : `IRS_VEC_ADDR_LO;
         if (state_r == ST_HOLD) begin
            // [R12] flag presets
            cpu_flags_r <= `IRS_FLAGS_RESET;
            // [R13] bank and page presets
            new_code_bank_r <= `IRS_NB_RESET;
            expand_page_r <= `IRS_EP_RESET;
            expand_page_x_r <= `IRS_EP_RESET;
            expand_page_y_r <= `IRS_EP_RESET;
         end
         if (state_r == ST_VHI) begin
            vec_lo_r <= vec_data;
         end
         // [R14] program counter from vector, bank copied
         if (state_r == ST_LOAD) begin
            pc_init_r <= {vec_data, vec_lo_r};
            current_code_bank_r <= new_code_bank_r;
         end
      end
   end

   // ****************************************************************
   // register port
   // ****************************************************************
   // cause flags are sticky; a write of 1 clears, but a live source wins
   always @(posedge clk) begin
      if (srst) begin
         cause_r <= 3'h0;
      end else begin
         if (reg_wr && reg_addr == `IRS_ADDR_CAUSE) begin
            cause_r <= cause_r & ~reg_wdata[2:0];
         end
         if (!pin_s2_r) begin
            cause_r[`IRS_CA_PIN] <= 1'b1;
         end
         if (key_hold_r || key_pulse) begin
            cause_r[`IRS_CA_KEY] <= 1'b1;
         end
         if (svd_trip_r) begin
            cause_r[`IRS_CA_SVD] <= 1'b1;
         end
      end
   end

   // read data stands only in the cycle after the strobe; unmapped reads give zero
   always @(posedge clk) begin
      if (srst) begin
         reg_rdata_r <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            `IRS_ADDR_STATUS: reg_rdata_r <= {4'h0, key_low, svd_trip_r, cpu_reset_r, svd_busy};
            `IRS_ADDR_CAUSE: reg_rdata_r <= {5'h00, cause_r};
            `IRS_ADDR_PC_LO: reg_rdata_r <= pc_init_r[7:0];
            `IRS_ADDR_PC_HI: reg_rdata_r <= pc_init_r[15:8];
            default: reg_rdata_r <= 8'h00;
         endcase
      end else begin
         reg_rdata_r <= 8'h00;
      end
   end

endmodule

// *** irs_board.sv ***
// board model: vector memory and supply monitor sampler
// assumes the sequencer clk; the bench sets the supply level
`timescale 1ns/100ps

module irs_board #(
   parameter [7:0] VEC_LO = 8'h34,
   parameter [7:0] VEC_HI = 8'h12
) (
   input wire clk,
   input wire vec_rd_r,
   input wire [23:0] vec_addr_r,
   input wire [1:0] supply_lvl,
   output reg [7:0] vec_data,
   output reg svd_sample_stb,
   output reg svd_below_l0,
   output reg svd_at_l2
);
   reg [4:0] pace_r;
   wire smp;
   assign smp = pace_r == 5'h1f;
   initial begin
      vec_data = 8'h00;
      svd_sample_stb = 1'b0;
      svd_below_l0 = 1'b0;
      svd_at_l2 = 1'b0;
      pace_r = 5'h00;
   end
   // *****
   // answers
   // *****
   // outside a read the byte toggles so stale data never looks valid
   always @(posedge clk) begin
      if (vec_rd_r && vec_addr_r == 24'h000000)
         vec_data <= VEC_LO;
      else if (vec_rd_r && vec_addr_r == 24'h000001)
         vec_data <= VEC_HI;
      else
         vec_data <= ~vec_data;
   end
   // one sample per 32 cycles; levels mean nothing off the strobe
   always @(posedge clk) begin
      pace_r <= pace_r + 5'h01;
      svd_sample_stb <= smp;
      svd_below_l0 <= smp ? supply_lvl == 2'h0 : ~svd_below_l0;
      svd_at_l2 <= smp ? supply_lvl == 2'h2 : ~svd_at_l2;
   end
endmodule

// *** initial_reset_sequencer_chk.sv ***
// checker of the initial reset sequencer ports
// assumes one clk domain with synchronous srst
`timescale 1ns/100ps

module initial_reset_sequencer_chk #(
   parameter LS_DIV = 4,
   parameter OSC_TICKS = 8
) (
   input wire clk,
   input wire srst,
   input wire reset_pin_n,
   input wire key_pin_0,
   input wire key_pin_1,
   input wire key_pin_2,
   input wire key_pin_3,
   input wire sleep_active,
   input wire svd_sample_stb,
   input wire [7:0] vec_data,
   input wire vec_rd_r,
   input wire [23:0] vec_addr_r,
   input wire cpu_reset_r,
   input wire cpu_start_r,
   input wire [15:0] pc_init_r,
   input wire [7:0] cpu_flags_r,
   input wire [7:0] new_code_bank_r,
   input wire [7:0] current_code_bank_r,
   input wire [7:0] expand_page_r,
   input wire [7:0] expand_page_x_r,
   input wire [7:0] expand_page_y_r,
   input wire svd_busy,
   input wire [3:0] reg_addr,
   input wire reg_rd,
   input wire [7:0] reg_rdata_r
);
   localparam int MIN_GAP = (OSC_TICKS + 247) * LS_DIV;
   reg [15:0] quiet_r;
   wire keys_low;
   assign keys_low = !(key_pin_0 | key_pin_1 | key_pin_2 | key_pin_3);
   // *****
   // helpers
   // *****
   // cycles since the pin was last low; saturates instead of wrapping
   always @(posedge clk) begin
      if (srst || !reset_pin_n)
         quiet_r <= 16'h0000;
      else if (quiet_r != 16'hffff)
         quiet_r <= quiet_r + 16'h0001;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   sequence fetch_s;
      vec_rd_r && vec_addr_r == 24'h000000 ##1 vec_rd_r && vec_addr_r == 24'h000001
      ##1 !vec_rd_r ##1 cpu_start_r && !cpu_reset_r;
   endsequence
   a_fetch_order: assert property ($rose(vec_rd_r) |-> fetch_s)
      else $error("vector fetch out of order");
   a_pc_load: assert property (cpu_start_r |-> pc_init_r == {$past(vec_data), $past(vec_data, 2)})
      else $error("pc not taken from vector");
   a_bank_copy: assert property (cpu_start_r |-> current_code_bank_r == new_code_bank_r)
      else $error("code bank not copied");
   a_reset_presets: assert property (cpu_reset_r |-> cpu_flags_r == 8'hc0 && new_code_bank_r == 8'h01
      && {expand_page_r, expand_page_x_r, expand_page_y_r} == 24'h000000)
      else $error("reset presets wrong");
   a_pin_holds: assert property (!reset_pin_n [*8] |-> ##3 cpu_reset_r)
      else $error("pin low without cpu reset");
   a_sleep_bypass: assert property (sleep_active && keys_low [*8] |-> ##4 cpu_reset_r)
      else $error("sleep key low without cpu reset");
   a_start_gap: assert property (cpu_start_r |-> quiet_r >= MIN_GAP)
      else $error("cpu start before waits");
   a_busy_holds: assert property (svd_busy && !svd_sample_stb |=> svd_busy)
      else $error("busy dropped without sample");
   a_read_idle: assert property (!reg_rd || reg_addr[1:0] != 2'h0 |=> reg_rdata_r == 8'h00)
      else $error("read data outside read slot");
   a_status_read: assert property (reg_rd && reg_addr == 4'h0 |=> reg_rdata_r[1] == $past(cpu_reset_r))
      else $error("status reset bit wrong");
endmodule

bind initial_reset_sequencer initial_reset_sequencer_chk #(
   .LS_DIV(LS_DIV),
   .OSC_TICKS(OSC_TICKS)
) chk_i (.*);

// *** initial_reset_sequencer_test.sv ***
// self-checking bench of the initial reset sequencer
// assumes the board model answers vector reads and paces samples
`timescale 1ns/100ps

module initial_reset_sequencer_test;
   localparam int LSD = 4;
   localparam int OSC = 8;
   localparam int WAITS = (OSC + 247) * LSD;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic reset_pin_n = 1'b0;
   logic [3:0] keys = 4'hf;
   logic sleep_active = 1'b0;
   logic [1:0] supply_lvl = 2'h1;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   wire stb, below, at_l2, vec_rd_r, cpu_reset_r, cpu_start_r, svd_busy;
   wire [7:0] vec_data, flags, nb, cb, rdata;
   wire [23:0] vec_addr;
   wire [15:0] pc;
   int errors = 0;
   int comparisons = 0;
   int n;
   always #2.5 clk = ~clk;

   initial_reset_sequencer #(.LS_DIV(LSD), .QUAL_TICKS(16), .OSC_TICKS(OSC))
   initial_reset_sequencer_i (.clk(clk), .srst(srst), .reset_pin_n(reset_pin_n),
      .key_pin_0(keys[0]), .key_pin_1(keys[1]), .key_pin_2(keys[2]), .key_pin_3(keys[3]),
      .sleep_active(sleep_active), .svd_sample_stb(stb), .svd_below_l0(below),
      .svd_at_l2(at_l2), .vec_data(vec_data), .vec_rd_r(vec_rd_r), .vec_addr_r(vec_addr),
      .cpu_reset_r(cpu_reset_r), .cpu_start_r(cpu_start_r), .pc_init_r(pc),
      .cpu_flags_r(flags), .new_code_bank_r(nb), .current_code_bank_r(cb),
      .expand_page_r(), .expand_page_x_r(), .expand_page_y_r(), .svd_busy(svd_busy),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata_r(rdata));
   irs_board irs_board_i (.clk(clk), .vec_rd_r(vec_rd_r), .vec_addr_r(vec_addr),
      .supply_lvl(supply_lvl), .vec_data(vec_data), .svd_sample_stb(stb),
      .svd_below_l0(below), .svd_at_l2(at_l2));

   // *****
   // helpers
   // *****
   task summarize;
      if (errors == 0 && comparisons > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      comparisons++;
      if (g !== e) begin
         errors++;
         $display("mismatch %s exp %h seen %h", nm, e, g);
      end
   endtask
   task idle(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   // bounded wait for the cpu reset level; n keeps the cycle count
   task wait_rst(input logic v, input int lim);
      n = 0;
      while (cpu_reset_r !== v && n < lim) begin
         @(posedge clk);
         #1 n++;
      end
      if (n >= lim) begin
         errors++;
         $display("mismatch cpu_reset_r exp %b seen %b", v, cpu_reset_r);
         summarize();
      end
   endtask
   task rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 chk("reg_rdata_r", e, rdata);
   endtask
   task wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   // *****
   // scenarios
   // *****
   // power-on with a weak supply: start waits for a good sample
   task t_boot;
      repeat (3) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      #1 chk("svd_busy", 1, svd_busy);
      repeat (2) @(posedge clk);
      reset_pin_n <= 1'b1;
      idle(1500);
      chk("svd_busy_done", 0, svd_busy);
      chk("weak_supply_hold", 1, cpu_reset_r);
      @(posedge clk);
      supply_lvl <= 2'h2;
      wait_rst(0, 100);
      chk("pc_init_r", 16'h1234, pc);
      chk("current_bank", 8'h01, cb);
      chk("flags", 8'hc0, flags);
   endtask
   // read-only and unmapped places, cause clear
   task t_regs;
      rd(4'hc, 8'h12);
      rd(4'h4, 8'h01);
      wr(4'h0, 8'hff);
      wr(4'h4, 8'h07);
      rd(4'h4, 8'h00);
      rd(4'h6, 8'h00);
      rd(4'h0, 8'h00);
   endtask
   task t_pin;
      @(posedge clk);
      reset_pin_n <= 1'b0;
      wait_rst(1, 16);
      idle(20);
      @(posedge clk);
      reset_pin_n <= 1'b1;
      wait_rst(0, 1200);
      chk("pin_wait", 1, n >= WAITS);
   endtask
   // a mid level after a trip must not release reset
   task t_svd;
      @(posedge clk);
      supply_lvl <= 2'h0;
      wait_rst(1, 300);
      @(posedge clk);
      supply_lvl <= 2'h1;
      idle(1400);
      chk("svd_hold", 1, cpu_reset_r);
      rd(4'h4, 8'h05);
      wr(4'h4, 8'h07);
      @(posedge clk);
      supply_lvl <= 2'h2;
      wait_rst(0, 1300);
      wr(4'h4, 8'h07);
   endtask
   // keys stay low the whole time yet the cpu restarts
   task t_key_run;
      @(posedge clk);
      keys <= 4'h8;
      idle(200);
      chk("partial_group", 0, cpu_reset_r);
      @(posedge clk);
      keys <= 4'h0;
      idle(56);
      chk("qualify_early", 0, cpu_reset_r);
      wait_rst(1, 40);
      wait_rst(0, 2000);
      chk("pulse_len", 1, n >= (64 + OSC + 247) * LSD);
      rd(4'h4, 8'h02);
      wr(4'h4, 8'h07);
      @(posedge clk);
      keys <= 4'hf;
   endtask
   task t_key_sleep;
      idle(10);
      sleep_active <= 1'b1;
      keys <= 4'h0;
      wait_rst(1, 12);
      idle(600);
      chk("sleep_hold", 1, cpu_reset_r);
      @(posedge clk);
      keys <= 4'hf;
      sleep_active <= 1'b0;
      wait_rst(0, 1200);
      chk("sleep_wait", 1, n >= WAITS);
   endtask

   initial begin
      t_boot();
      t_regs();
      t_pin();
      t_svd();
      t_key_run();
      t_key_sleep();
      summarize();
   end
endmodule
